/* rtl/dlg_pkg.sv */
// Package: register map, field layouts and codes of the data logger store control block
package dlg_pkg;

	localparam int ADDR_W = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CONTROL    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STORE_CODE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ERROR_CODE = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_REC_COUNT  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_REC_LIMIT  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h20;

	// Status register bit positions
	localparam int ST_CARD_PRESENT = 0;
	localparam int ST_STORING      = 1;
	localparam int ST_CARD_ERROR   = 2;
	localparam int ST_LIMIT        = 3;
	localparam int ST_PARAMS_VALID = 4;

	// Control register bit positions
	localparam int CT_RECORD_EN    = 0;
	localparam int CT_STORE_ACT    = 1;
	localparam int CT_CYCLIC       = 2;

	// Interrupt event bit positions
	localparam int EV_STORE_DONE   = 0;
	localparam int EV_CARD_ERROR   = 1;
	localparam int EV_LIMIT        = 2;
	localparam int EV_CARD_CHANGE  = 3;
	localparam int EV_W            = 4;

	// Store control codes
	localparam logic [15:0] CODE_STORE_REQ = 16'h5aa5;
	localparam logic [15:0] CODE_DONE      = 16'h0000;

	// Reset values
	localparam logic [31:0] REC_LIMIT_RST  = 32'h0000_0000;
	localparam logic [15:0] ERR_CODE_RST   = 16'h0000;

	typedef enum logic [1:0] {
		DLG_IDLE,
		DLG_STORE
	} dlg_state_e;

	// Request to the card writer and its answer
	typedef struct packed {
		logic start;
	} dlg_store_req_s;

	typedef struct packed {
		logic        done;
		logic        fail;
		logic [15:0] code;
	} dlg_store_rsp_s;

endpackage : dlg_pkg

/* rtl/dlg_store_ctrl.sv */
// Module: data logger store control and status register bank on classic Wishbone
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - Card present flag mirrors card detect
// - Storing flag high during card write
// - Card error flag set on failure
// - Latch last failure code for software
// - Record only while record enable set
// - Hardware never clears record enable
// - Limit flag on count limit or cyclic
// - Code 5AA5 requests store, 0 done
// - Store starts on activate rising edge
// - Params valid flag after parameter load
// - 32-bit record counter increments per record
// - Writes to read-only items ignored
// - Auto store on limit or count reached
module dlg_store_ctrl (
	// Clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       reset_n,
	// Wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [dlg_pkg::ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	output logic                            wb_err_o,
	// Card pins, asynchronous
	input  wire logic                       card_detect,
	// Logger core, same clock
	input  wire logic                       sample_strobe,
	input  wire logic                       params_loaded,
	output logic                            recording,
	// Card writer, same clock
	output dlg_pkg::dlg_store_req_s         store_req,
	input  wire dlg_pkg::dlg_store_rsp_s    store_rsp,
	// Interrupt
	output logic                            irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Card detect synchroniser

	logic card_meta_q;
	logic card_sync_q;
	logic card_prev_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			card_meta_q <= 1'b0;
			card_sync_q <= 1'b0;
			card_prev_q <= 1'b0;
		end else begin
			card_meta_q <= card_detect;
			card_sync_q <= card_meta_q;
			card_prev_q <= card_sync_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic        ack_q;
	logic [31:0] rdata_q;
	logic        err_q;

	wire         bus_req   = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
	wire         addr_ok   = (wb_adr_i == dlg_pkg::OFF_STATUS)
		| (wb_adr_i == dlg_pkg::OFF_CONTROL)    | (wb_adr_i == dlg_pkg::OFF_STORE_CODE)
		| (wb_adr_i == dlg_pkg::OFF_ERROR_CODE) | (wb_adr_i == dlg_pkg::OFF_REC_COUNT)
		| (wb_adr_i == dlg_pkg::OFF_REC_LIMIT)  | (wb_adr_i == dlg_pkg::OFF_IRQ_STATUS)
		| (wb_adr_i == dlg_pkg::OFF_IRQ_ENABLE) | (wb_adr_i == dlg_pkg::OFF_IRQ_CLEAR);
	wire         wr        = bus_req & wb_we_i & addr_ok;
	// Only writable offsets are decoded for writes; read-only ones fall through
	wire         wr_ctrl   = wr & (wb_adr_i == dlg_pkg::OFF_CONTROL);
	wire         wr_code   = wr & (wb_adr_i == dlg_pkg::OFF_STORE_CODE);
	wire         wr_limit  = wr & (wb_adr_i == dlg_pkg::OFF_REC_LIMIT);
	wire         wr_ien    = wr & (wb_adr_i == dlg_pkg::OFF_IRQ_ENABLE);
	wire         wr_iclr   = wr & (wb_adr_i == dlg_pkg::OFF_IRQ_CLEAR);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	logic        rec_en_q;
	logic        act_q;
	logic        act_prev_q;
	logic        cyclic_q;
	logic [15:0] code_q;
	logic [15:0] code_d;
	logic [31:0] limit_q;
	localparam int EV_W_L = dlg_pkg::EV_W;
	logic [EV_W_L-1:0] ien_q;

	wire  [31:0] ctrl_new  = merge({29'h0, cyclic_q, act_q, rec_en_q}, wb_dat_i, wb_sel_i);

	// Record enable only changes by software write
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rec_en_q   <= 1'b0;
			act_q      <= 1'b0;
			act_prev_q <= 1'b0;
			cyclic_q   <= 1'b0;
			limit_q    <= dlg_pkg::REC_LIMIT_RST;
			ien_q      <= '0;
		end else begin
			act_prev_q <= act_q;
			if (wr_ctrl) begin
				rec_en_q <= ctrl_new[dlg_pkg::CT_RECORD_EN];
				act_q    <= ctrl_new[dlg_pkg::CT_STORE_ACT];
				cyclic_q <= ctrl_new[dlg_pkg::CT_CYCLIC];
			end
			if (wr_limit) begin
				limit_q <= merge(limit_q, wb_dat_i, wb_sel_i);
			end
			if (wr_ien) begin
				ien_q <= wb_dat_i[EV_W_L-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Recording and limit

	logic [31:0] count_q;
	logic        limit_hit_q;
	logic        limit_prev_q;
	logic        params_q;

	wire         rec_take  = rec_en_q & sample_strobe;
	wire         count_met = (limit_q != 32'h0) & (count_q >= limit_q);
	wire         limit_now = count_met | cyclic_q;

	assign recording = rec_en_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_q      <= 32'h0;
			limit_hit_q  <= 1'b0;
			limit_prev_q <= 1'b0;
			params_q     <= 1'b0;
		end else begin
			if (rec_take) begin
				count_q <= count_q + 32'h1;
			end
			limit_hit_q  <= limit_now;
			limit_prev_q <= limit_hit_q;
			if (params_loaded) begin
				params_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Store sequencer

	dlg_pkg::dlg_state_e state_q;
	dlg_pkg::dlg_state_e state_d;
	logic                err_flag_q;
	logic [15:0]         err_code_q;

	wire code_req  = (code_q == dlg_pkg::CODE_STORE_REQ);
	wire sw_start  = act_q & ~act_prev_q & code_req;
	wire auto_go   = limit_hit_q & ~limit_prev_q & code_req;
	wire idle      = (state_q == dlg_pkg::DLG_IDLE);
	wire start     = idle & (sw_start | auto_go) & card_sync_q;
	wire finish    = ~idle & (store_rsp.done | store_rsp.fail);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			dlg_pkg::DLG_IDLE:  if (start)  state_d = dlg_pkg::DLG_STORE;
			dlg_pkg::DLG_STORE: if (finish) state_d = dlg_pkg::DLG_IDLE;
			// Unused encodings fall back to idle
			default:            state_d = dlg_pkg::DLG_IDLE;
		endcase
	end

	wire [31:0] code_new = merge({16'h0, code_q}, wb_dat_i, wb_sel_i);

	// Completion clears the code in the same cycle the state drops
	always_comb begin
		code_d = code_q;
		if (wr_code) begin
			code_d = code_new[15:0];
		end
		if (finish) begin
			code_d = dlg_pkg::CODE_DONE;
		end
	end

	assign store_req.start = start;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q    <= dlg_pkg::DLG_IDLE;
			code_q     <= dlg_pkg::CODE_DONE;
			err_flag_q <= 1'b0;
			err_code_q <= dlg_pkg::ERR_CODE_RST;
		end else begin
			state_q <= state_d;
			code_q  <= code_d;
			if (finish & store_rsp.fail) begin
				err_flag_q <= 1'b1;
				err_code_q <= store_rsp.code;
			end else if (start) begin
				err_flag_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts

	logic [EV_W_L-1:0] ist_q;
	wire  [EV_W_L-1:0] ev;

	assign ev[dlg_pkg::EV_STORE_DONE]  = finish & store_rsp.done & ~store_rsp.fail;
	assign ev[dlg_pkg::EV_CARD_ERROR]  = finish & store_rsp.fail;
	assign ev[dlg_pkg::EV_LIMIT]       = limit_hit_q & ~limit_prev_q;
	assign ev[dlg_pkg::EV_CARD_CHANGE] = card_sync_q ^ card_prev_q;

	wire [EV_W_L-1:0] iclr = wr_iclr ? wb_dat_i[EV_W_L-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ist_q <= '0;
		end else begin
			ist_q <= (ist_q & ~iclr) | ev;
		end
	end

	assign irq = |(ist_q & ien_q);

	////////////////////////////////////////////////////////////////////////////////
	// Read mux and answer

	wire [31:0] status_w = {27'h0, params_q, limit_hit_q, err_flag_q,
		~idle, card_sync_q};

	logic [31:0] rmux;
	always_comb begin
		unique case (wb_adr_i)
			dlg_pkg::OFF_STATUS:     rmux = status_w;
			dlg_pkg::OFF_CONTROL:    rmux = {29'h0, cyclic_q, act_q, rec_en_q};
			dlg_pkg::OFF_STORE_CODE: rmux = {16'h0, code_q};
			dlg_pkg::OFF_ERROR_CODE: rmux = {16'h0, err_code_q};
			dlg_pkg::OFF_REC_COUNT:  rmux = count_q;
			dlg_pkg::OFF_REC_LIMIT:  rmux = limit_q;
			dlg_pkg::OFF_IRQ_STATUS: rmux = {{(32-EV_W_L){1'b0}}, ist_q};
			dlg_pkg::OFF_IRQ_ENABLE: rmux = {{(32-EV_W_L){1'b0}}, ien_q};
			default:                 rmux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q   <= bus_req & addr_ok;
			err_q   <= bus_req & ~addr_ok;
			rdata_q <= (bus_req & ~wb_we_i) ? rmux : 32'h0;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdata_q;

endmodule : dlg_store_ctrl

/* dv/dlg_card_model.sv */
// Partner: card writer that answers each store start with done or fail
`timescale 1ns/1ps
module dlg_card_model (
	// Clock and reset
	input	wire logic			clk_sys,
	input	wire logic			reset_n,
	// Store handshake
	input	wire dlg_pkg::dlg_store_req_s	store_req,
	output	dlg_pkg::dlg_store_rsp_s	store_rsp,
	// Bench controls
	input	wire logic			fail_en,
	input	wire logic [15:0]		fail_code,
	input	wire logic [7:0]		lag
);
	int	left_q;
	////////////////////////////////////////////////////////////////////////////////
	// Code toggles outside a done or fail pulse, so a stale value never reads as good
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			left_q <= -1;
			store_rsp <= '0;
		end else begin
			store_rsp.done <= 1'b0;
			store_rsp.fail <= 1'b0;
			store_rsp.code <= ~store_rsp.code;
			if (store_req.start)
				left_q <= int'(lag);
			else if (left_q > 0)
				left_q <= left_q - 1;
			else if (left_q == 0) begin
				left_q <= -1;
				store_rsp.done <= !fail_en;
				store_rsp.fail <= fail_en;
				store_rsp.code <= fail_code;
			end
		end
	end
endmodule : dlg_card_model

/* dv/dlg_store_ctrl_props.sv */
// Checker: bus and control properties of the store control block
`timescale 1ns/1ps
module dlg_store_ctrl_props (
	// Clock and reset
	input	wire logic			clk_sys,
	input	wire logic			reset_n,
	// Bus
	input	wire logic			wb_cyc_i,
	input	wire logic			wb_stb_i,
	input	wire logic			wb_we_i,
	input	wire logic [7:0]		wb_adr_i,
	input	wire logic [3:0]		wb_sel_i,
	input	wire logic [31:0]		wb_dat_i,
	input	wire logic [31:0]		wb_dat_o,
	input	wire logic			wb_ack_o,
	input	wire logic			wb_err_o,
	// Side ports
	input	wire logic			recording,
	input	wire dlg_pkg::dlg_store_req_s	store_req,
	input	wire logic			irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire	req_new = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire	ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == dlg_pkg::OFF_CONTROL && wb_sel_i[0];
	wire	ien_wr = wb_ack_o && wb_we_i && wb_adr_i == dlg_pkg::OFF_IRQ_ENABLE;
	////////////////////////////////////////////////////////////////////////////////
	property p_ack_lat; req_new |=> (wb_ack_o || wb_err_o); endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("bus answer late");
	property p_ack_pulse; (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o); endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("bus answer too long");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
	property p_err_map; (req_new && wb_adr_i > 8'h20) |=> (wb_err_o && !wb_ack_o); endproperty
	a_err_map: assert property (p_err_map) else $error("unmapped not refused");
	property p_rec_set; ctl_wr |=> recording == $past(wb_dat_i[0]); endproperty
	a_rec_set: assert property (p_rec_set) else $error("record enable not written");
	property p_rec_keep; $changed(recording) |-> ($past(ctl_wr) || ctl_wr); endproperty
	a_rec_keep: assert property (p_rec_keep) else $error("record enable moved alone");
	property p_start_one; store_req.start |=> !store_req.start; endproperty
	a_start_one: assert property (p_start_one) else $error("start not a pulse");
	property p_irq_off; (ien_wr && wb_dat_i[3:0] == 4'h0) |=> ##1 !irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked irq high");
endmodule : dlg_store_ctrl_props

bind dlg_store_ctrl dlg_store_ctrl_props i_props (.*);

/* dv/dlg_store_ctrl_tb_top.sv */
// Bench: store control block against a model of its rules
`timescale 1ns/1ps
module dlg_store_ctrl_tb_top;
	logic				clk_sys = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, e;
	logic [7:0]			wb_adr_i = '0;
	logic [3:0]			wb_sel_i = 4'hf;
	logic [31:0]			wb_dat_i = '0, wb_dat_o, q;
	logic				wb_ack_o, wb_err_o, recording, irq;
	logic				card_detect = 0, sample_strobe = 0, params_loaded = 0, fail_en = 0;
	logic [15:0]			fail_code = '0, fc;
	dlg_pkg::dlg_store_req_s	store_req;
	dlg_pkg::dlg_store_rsp_s	store_rsp;
	int				n_fail = 0, cmp_count = 0, m_cnt = 0, n;
	dlg_store_ctrl i_dut (.*);
	dlg_card_model i_card (.*, .lag(8'h1e));
	initial forever #2 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	task automatic chk(input string s, input logic [31:0] v, input logic [31:0] x);
		cmp_count++;
		if (v !== x) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", s, x, v);
		end
	endtask : chk
	// Request held until the answer; never assumes a latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_sys);
			k++;
		end while (!(wb_ack_o | wb_err_o) && k < 50);
		q = wb_dat_o;
		e = wb_err_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (k >= 50) begin
			n_fail++;
			test_done();
		end
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task automatic rd(input string s, input logic [7:0] a, input logic [31:0] x);
		wb(1'b0, a, '0);
		chk(s, q, x);
	endtask : rd
	task automatic ir(input logic x);
		repeat (2) @(posedge clk_sys);
		chk("irq", {31'h0, irq}, {31'h0, x});
	endtask : ir
	task automatic strobe(input int c, input bit rec);
		repeat (c) begin
			@(posedge clk_sys) sample_strobe <= 1'b1;
			@(posedge clk_sys) sample_strobe <= 1'b0;
			m_cnt += int'(rec);
		end
	endtask : strobe
	task automatic wt;
		int k;
		for (k = 0; k < 200 && !(store_rsp.done | store_rsp.fail); k++) @(posedge clk_sys);
		repeat (3) @(posedge clk_sys);
		if (k == 200) begin
			n_fail++;
			test_done();
		end
	endtask : wt
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h2b01));
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd("status", dlg_pkg::OFF_STATUS, '0);
		card_detect <= 1'b1;
		params_loaded <= 1'b1;
		@(posedge clk_sys) params_loaded <= 1'b0;
		wr(dlg_pkg::OFF_STATUS, '1);
		rd("status", dlg_pkg::OFF_STATUS, 32'h11);
		strobe($urandom_range(9, 1), 1'b0);
		n = $urandom_range(9, 1);
		wr(dlg_pkg::OFF_STORE_CODE, 32'h5aa5);
		wr(dlg_pkg::OFF_REC_LIMIT, 32'(n));
		wr(dlg_pkg::OFF_CONTROL, 32'h1);
		strobe(n, 1'b1);
		repeat (4) @(posedge clk_sys);
		rd("status", dlg_pkg::OFF_STATUS, 32'h1b);
		wt();
		rd("code", dlg_pkg::OFF_STORE_CODE, '0);
		rd("count", dlg_pkg::OFF_REC_COUNT, 32'(m_cnt));
		wr(dlg_pkg::OFF_REC_COUNT, '1);
		rd("count", dlg_pkg::OFF_REC_COUNT, 32'(m_cnt));
		rd("control", dlg_pkg::OFF_CONTROL, 32'h1);
		rd("irq status", dlg_pkg::OFF_IRQ_STATUS, 32'hd);
		wr(dlg_pkg::OFF_IRQ_ENABLE, 32'h1);
		ir(1'b1);
		wr(dlg_pkg::OFF_IRQ_ENABLE, '0);
		ir(1'b0);
		wr(dlg_pkg::OFF_IRQ_CLEAR, 32'hf);
		rd("irq status", dlg_pkg::OFF_IRQ_STATUS, '0);
		// Bad code with a clean activate edge must not store
		wr(dlg_pkg::OFF_REC_LIMIT, '0);
		wr(dlg_pkg::OFF_STORE_CODE, 32'h1234);
		wr(dlg_pkg::OFF_CONTROL, 32'h3);
		repeat (4) @(posedge clk_sys);
		rd("status", dlg_pkg::OFF_STATUS, 32'h11);
		rd("code", dlg_pkg::OFF_STORE_CODE, 32'h1234);
		fc = 16'($urandom);
		fail_code <= fc;
		fail_en <= 1'b1;
		wr(dlg_pkg::OFF_CONTROL, 32'h1);
		wr(dlg_pkg::OFF_STORE_CODE, 32'h5aa5);
		wr(dlg_pkg::OFF_CONTROL, 32'h3);
		wt();
		rd("status", dlg_pkg::OFF_STATUS, 32'h15);
		rd("error code", dlg_pkg::OFF_ERROR_CODE, {16'h0, fc});
		rd("code", dlg_pkg::OFF_STORE_CODE, '0);
		wr(dlg_pkg::OFF_CONTROL, 32'h5);
		rd("status", dlg_pkg::OFF_STATUS, 32'h1d);
		card_detect <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd("status", dlg_pkg::OFF_STATUS, 32'h1c);
		wb(1'b0, 8'h24, '0);
		chk("err", {31'h0, e}, 32'h1);
		test_done();
	end
endmodule : dlg_store_ctrl_tb_top
